// ---- core/hs_transimpedance_cfg_regs.sv ----
// AHB-Lite register bank for the high-speed transimpedance amplifier configuration
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Gain select bits 3:0 reset to 0xF; codes 8 to 15 leave resistor open.
// - Capacitor field bits 12:5 resets zero; low six bits add 1 to 32 pF.
// - Diode switch bit 4 resets zero; one places diode across gain resistor.
// - Gain, capacitor and diode register at 0x20F0, reset value 0xF.
// - Pin resistor register at 0x20F8, low byte resets all ones.
// - Amplifier input register at 0x20FC, read-write, resets to zero.
// - Input select bits 1:0: 00 internal bias, 01 zero-bias DAC, others reserved.
// - Pin code 0x97 shorts both load and gain resistors on the pin.
module hs_transimpedance_cfg_regs
  import tia_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Gain network selects
  output logic [7:0] gain_res_onehot,
  output logic gain_res_open,
  output logic [5:0] cap_enable,
  output logic diode_switch,
  // Electrode pin network selects
  output logic [7:0] pin_load_gain_code,
  output logic pin_short_both,
  output logic pin_disconnected,
  // Positive input selects
  output logic sel_internal_bias,
  output logic sel_zero_bias_dac
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [GAIN_SEL_W-1:0] gain_sel_ff, nxt_gain_sel;
  logic [CAP_SEL_W-1:0] cap_sel_ff, nxt_cap_sel;
  logic diode_ff, nxt_diode;
  logic [PIN_CODE_W-1:0] pin_code_ff, nxt_pin_code;
  logic [INPUT_SEL_W-1:0] input_sel_ff, nxt_input_sel;
  logic wr_pend_ff, nxt_wr_pend;
  logic [31:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] rd_word;
  logic addr_phase;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Read mux; reserved bits zero, unmapped reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr == GAIN_CFG_ADDR) begin
      rd_word[GAIN_SEL_LSB +: GAIN_SEL_W] = gain_sel_ff;
      rd_word[DIODE_BIT] = diode_ff;
      rd_word[CAP_SEL_LSB +: CAP_SEL_W] = cap_sel_ff;
    end else if (haddr == PIN_CFG_ADDR) begin
      rd_word[PIN_CODE_W-1:0] = pin_code_ff;
    end else if (haddr == INPUT_CFG_ADDR) begin
      rd_word[INPUT_SEL_W-1:0] = input_sel_ff;
    end
  end

  // Next values: capture address phase, write in data phase
  always_comb begin
    nxt_gain_sel = gain_sel_ff;
    nxt_cap_sel = cap_sel_ff;
    nxt_diode = diode_ff;
    nxt_pin_code = pin_code_ff;
    nxt_input_sel = input_sel_ff;
    nxt_wr_pend = addr_phase && hwrite;
    nxt_wr_addr = addr_phase ? haddr : wr_addr_ff;
    nxt_rdata = (addr_phase && !hwrite) ? rd_word : rdata_ff;
    if (wr_pend_ff) begin
      if (wr_addr_ff == GAIN_CFG_ADDR) begin
        nxt_gain_sel = hwdata[GAIN_SEL_LSB +: GAIN_SEL_W];
        nxt_diode = hwdata[DIODE_BIT];
        nxt_cap_sel = hwdata[CAP_SEL_LSB +: CAP_SEL_W];
      end else if (wr_addr_ff == PIN_CFG_ADDR) begin
        nxt_pin_code = hwdata[PIN_CODE_W-1:0];
      end else if (wr_addr_ff == INPUT_CFG_ADDR) begin
        nxt_input_sel = hwdata[INPUT_SEL_W-1:0];
      end
    end
  end

  // Registers with documented reset values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gain_sel_ff <= GAIN_SEL_RST;
      cap_sel_ff <= CAP_SEL_RST;
      diode_ff <= DIODE_RST;
      pin_code_ff <= PIN_CODE_RST;
      input_sel_ff <= INPUT_SEL_RST;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
    end else begin
      gain_sel_ff <= nxt_gain_sel;
      cap_sel_ff <= nxt_cap_sel;
      diode_ff <= nxt_diode;
      pin_code_ff <= nxt_pin_code;
      input_sel_ff <= nxt_input_sel;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign pin_load_gain_code = pin_code_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders
  tia_gain_decode u_gain (
    .gain_resistor_select(gain_sel_ff),
    .feedback_cap_select(cap_sel_ff),
    .protect_diode_switch(diode_ff),
    .gain_res_onehot(gain_res_onehot),
    .gain_res_open(gain_res_open),
    .cap_enable(cap_enable),
    .diode_switch(diode_switch)
  );

  tia_pin_decode u_pin (
    .pin_load_gain_code(pin_code_ff),
    .positive_input_select(input_sel_ff),
    .pin_short_both(pin_short_both),
    .pin_disconnected(pin_disconnected),
    .sel_internal_bias(sel_internal_bias),
    .sel_zero_bias_dac(sel_zero_bias_dac)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_gain_reset: assert property (@(posedge clk) $past(sys_rst) |-> gain_sel_ff == 4'hF && !diode_ff)
    else $error("gain register reset value wrong");
  a_pin_reset: assert property (@(posedge clk) $past(sys_rst) |-> pin_code_ff == 8'hFF)
    else $error("pin register reset value wrong");
  a_input_reset: assert property (@(posedge clk) $past(sys_rst) |-> input_sel_ff == 2'h0)
    else $error("input register reset value wrong");
  a_gain_open: assert property (@(posedge clk) disable iff (sys_rst) gain_res_open == gain_sel_ff[3])
    else $error("open resistor decode wrong");
  a_gain_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_pend_ff && wr_addr_ff == 32'h0000_20F0 |=> gain_sel_ff == $past(hwdata[3:0]) && cap_sel_ff == $past(hwdata[12:5]))
    else $error("gain register write lost");
  a_diode_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_pend_ff && wr_addr_ff == 32'h0000_20F0 |=> diode_switch == $past(hwdata[4]))
    else $error("diode switch write lost");
  a_input_sel: assert property (@(posedge clk) disable iff (sys_rst)
    sel_zero_bias_dac |-> input_sel_ff == 2'h1 && !sel_internal_bias)
    else $error("input source decode wrong");
  a_ext_short: assert property (@(posedge clk) disable iff (sys_rst)
    wr_pend_ff && wr_addr_ff == 32'h0000_20F8 && hwdata[7:0] == 8'h97 |=> pin_short_both)
    else $error("external gain short missing");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
    $past(addr_phase && !hwrite && haddr == 32'h0000_20FC) |-> hrdata[31:2] == 30'h0)
    else $error("reserved bits not zero");
  c_gain_write: cover property (@(posedge clk) wr_pend_ff && wr_addr_ff == GAIN_CFG_ADDR);
  c_ext_gain: cover property (@(posedge clk) pin_short_both);
  c_dac_source: cover property (@(posedge clk) sel_zero_bias_dac);

endmodule // hs_transimpedance_cfg_regs
`default_nettype wire

// ---- common/tia_cfg_pkg.sv ----
// Package with register map, field layout and reset values of the transimpedance configuration bank
`default_nettype none
package tia_cfg_pkg;

  // Register byte addresses
  localparam logic [31:0] GAIN_CFG_ADDR = 32'h0000_20F0;
  localparam logic [31:0] PIN_CFG_ADDR = 32'h0000_20F8;
  localparam logic [31:0] INPUT_CFG_ADDR = 32'h0000_20FC;

  // Field positions inside the gain, capacitor and diode register, then pin and input field widths
  localparam int GAIN_SEL_LSB = 0;
  localparam int GAIN_SEL_W = 4;
  localparam int DIODE_BIT = 4;
  localparam int CAP_SEL_LSB = 5;
  localparam int CAP_SEL_W = 8;
  localparam int CAP_USED_W = 6;
  localparam int PIN_CODE_W = 8;
  localparam int INPUT_SEL_W = 2;

  // Reset values
  localparam logic [GAIN_SEL_W-1:0] GAIN_SEL_RST = 4'hF;
  localparam logic [CAP_SEL_W-1:0] CAP_SEL_RST = 8'h00;
  localparam logic DIODE_RST = 1'b0;
  localparam logic [PIN_CODE_W-1:0] PIN_CODE_RST = 8'hFF;
  localparam logic [INPUT_SEL_W-1:0] INPUT_SEL_RST = 2'h0;

  // Special codes
  localparam logic [PIN_CODE_W-1:0] PIN_CODE_EXT_GAIN = 8'h97;

  // Positive input sources
  typedef enum logic [1:0] {
    SRC_INTERNAL_BIAS = 2'h0,
    SRC_ZERO_BIAS_DAC = 2'h1,
    SRC_RSVD_2 = 2'h2,
    SRC_RSVD_3 = 2'h3
  } input_src_t;

  // AHB transfer type codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage
`default_nettype wire

// ---- core/tia_gain_decode.sv ----
// Decoder from stored gain, capacitor and diode codes to analog switch selects
`timescale 1ns/1ns
`default_nettype none
module tia_gain_decode
  import tia_cfg_pkg::*;
(
  // Stored fields
  input wire logic [GAIN_SEL_W-1:0] gain_resistor_select,
  input wire logic [CAP_SEL_W-1:0] feedback_cap_select,
  input wire logic protect_diode_switch,
  // Switch selects
  output logic [7:0] gain_res_onehot,
  output logic gain_res_open,
  output logic [CAP_USED_W-1:0] cap_enable,
  output logic diode_switch
);

  ////////////////////////////////////////////////////////////////////////////
  // open codes
  // Codes with the top bit set leave the resistor open
  always_comb begin
    gain_res_onehot = 8'h00;
    gain_res_open = gain_resistor_select[GAIN_SEL_W-1];
    if (!gain_res_open) begin
      gain_res_onehot[gain_resistor_select[2:0]] = 1'b1;
    end
  end

  // binary capacitors
  // Only the low six bits steer capacitors; upper two are unused
  assign cap_enable = feedback_cap_select[CAP_USED_W-1:0];
  assign diode_switch = protect_diode_switch;

endmodule // tia_gain_decode
`default_nettype wire

// ---- core/tia_pin_decode.sv ----
// Decoder for the electrode pin resistor pair and positive input source
`timescale 1ns/1ns
`default_nettype none
module tia_pin_decode
  import tia_cfg_pkg::*;
(
  // Stored fields
  input wire logic [PIN_CODE_W-1:0] pin_load_gain_code,
  input wire logic [INPUT_SEL_W-1:0] positive_input_select,
  // Decoded controls
  output logic pin_short_both,
  output logic pin_disconnected,
  output logic sel_internal_bias,
  output logic sel_zero_bias_dac
);

  ////////////////////////////////////////////////////////////////////////////
  // external gain short
  assign pin_short_both = (pin_load_gain_code == PIN_CODE_EXT_GAIN);
  assign pin_disconnected = (pin_load_gain_code == PIN_CODE_RST);

  // source select
  // Reserved codes select neither source
  assign sel_internal_bias = (positive_input_select == SRC_INTERNAL_BIAS);
  assign sel_zero_bias_dac = (positive_input_select == SRC_ZERO_BIAS_DAC);

endmodule // tia_pin_decode
`default_nettype wire

// ---- bench/hs_transimpedance_cfg_regs_tb.sv ----
// Self-checking testbench for the transimpedance configuration register bank
`timescale 1ns/1ns
`default_nettype none
module hs_transimpedance_cfg_regs_tb import tia_cfg_pkg::*; ;
  logic clk, sys_rst, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic hreadyout, hresp, gain_res_open, diode_switch, pin_short_both, pin_disconnected;
  logic sel_internal_bias, sel_zero_bias_dac;
  logic [7:0] gain_res_onehot, pin_load_gain_code;
  logic [5:0] cap_enable;
  int error_cnt = 0;
  int total_checks = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Design under test, the single slave drives the bus ready
  hs_transimpedance_cfg_regs dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .gain_res_onehot(gain_res_onehot), .gain_res_open(gain_res_open), .cap_enable(cap_enable),
    .diode_switch(diode_switch), .pin_load_gain_code(pin_load_gain_code), .pin_short_both(pin_short_both),
    .pin_disconnected(pin_disconnected), .sel_internal_bias(sel_internal_bias),
    .sel_zero_bias_dac(sel_zero_bias_dac));

  // Clock of 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single AHB-Lite transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  // Write, then let the stored value settle on the outputs
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    @(negedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk("read data", rdat, exp);
  endtask

  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung bus
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("gain open", {31'h0, gain_res_open}, 32'h1);
    chk("pin off", {31'h0, pin_disconnected}, 32'h1);
    chk("bias src", {31'h0, sel_internal_bias}, 32'h1);
    rd(GAIN_CFG_ADDR, 32'h0000_000F);
    rd(PIN_CFG_ADDR, 32'h0000_00FF);
    rd(INPUT_CFG_ADDR, 32'h0000_0000);
    chk("response", {31'h0, hresp}, 32'h0);
    chk("ready", {31'h0, hreadyout}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      wr(GAIN_CFG_ADDR, 32'(i));
      chk("onehot", {24'h0, gain_res_onehot}, (i < 8) ? (32'h1 << i) : 32'h0);
      chk("open", {31'h0, gain_res_open}, (i >= 8) ? 32'h1 : 32'h0);
    end
    // all ones written, reserved bits dropped
    wr(GAIN_CFG_ADDR, 32'hFFFF_FFFF);
    rd(GAIN_CFG_ADDR, 32'h0000_1FFF);
    chk("cap", {26'h0, cap_enable}, 32'h0000_003F);
    chk("diode", {31'h0, diode_switch}, 32'h1);
    wr(GAIN_CFG_ADDR, 32'h0000_02A0);
    chk("cap", {26'h0, cap_enable}, 32'h0000_0015);
    chk("diode", {31'h0, diode_switch}, 32'h0);
    // short code, then plain code zero
    wr(PIN_CFG_ADDR, 32'hFFFF_FF97);
    rd(PIN_CFG_ADDR, 32'h0000_0097);
    chk("short", {31'h0, pin_short_both}, 32'h1);
    chk("pin code", {24'h0, pin_load_gain_code}, 32'h0000_0097);
    wr(PIN_CFG_ADDR, 32'h0000_0000);
    chk("short", {31'h0, pin_short_both}, 32'h0);
    chk("pin off", {31'h0, pin_disconnected}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(INPUT_CFG_ADDR, 32'hFFFF_FFFC | 32'(i));
      rd(INPUT_CFG_ADDR, 32'(i));
      chk("bias src", {31'h0, sel_internal_bias}, (i == 0) ? 32'h1 : 32'h0);
      chk("dac src", {31'h0, sel_zero_bias_dac}, (i == 1) ? 32'h1 : 32'h0);
    end
    wr(32'h0000_20F4, 32'hFFFF_FFFF);
    rd(32'h0000_20F4, 32'h0000_0000);
    rd(GAIN_CFG_ADDR, 32'h0000_02A0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("gain open", {31'h0, gain_res_open}, 32'h1);
    chk("pin off", {31'h0, pin_disconnected}, 32'h1);
    chk("bias src", {31'h0, sel_internal_bias}, 32'h1);
    rd(GAIN_CFG_ADDR, 32'h0000_000F);
    rd(PIN_CFG_ADDR, 32'h0000_00FF);
    rd(INPUT_CFG_ADDR, 32'h0000_0000);
    end_sim();
  end
endmodule // hs_transimpedance_cfg_regs_tb
`default_nettype wire
